// *** hdl/apf_pkg.sv ***
/*
 Package for the audio port, reset sequencing and fault report block.
 Assumes a 250 MHz system clock and a bit clock from the audio source.
*/
package apf_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] ERROR_STATUS_ADDR  = 8'h02;
   localparam int         STICKY_FAULT_BIT   = 1;
   localparam int         CLOCK_ERR_BIT      = 0;
   localparam logic [7:0] ERROR_STATUS_RESET = 8'h00;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int RESET_HOLD_US   = 100;
   localparam int RESET_HOLD_CYC  = (RESET_HOLD_US * 1000000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;

   // ------------------------------------------------------------
   // Bit clock ratios
   // ------------------------------------------------------------
   localparam logic [6:0] RATIO_32 = 7'h20;
   localparam logic [6:0] RATIO_48 = 7'h30;
   localparam logic [6:0] RATIO_64 = 7'h40;

   typedef enum logic [1:0]
   {
      APF_OFF     = 2'b00,
      APF_HOLD    = 2'b01,
      APF_IDLE    = 2'b10,
      APF_ACTIVE  = 2'b11
   } apf_state_e;

   // One received stereo frame
   typedef struct packed
   {
      logic [23:0] left;
      logic [23:0] right;
   } apf_frame_s;

   // Fault sources
   typedef struct packed
   {
      logic overcurrent;
      logic undervoltage;
      logic overtemperature_error;
      logic overvoltage;
   } apf_fault_s;

endpackage

// *** hdl/apf_link_rx.sv ***
/*
 I2S receiver on the bit clock domain.
 Assumes the source keeps 32..64 bit clocks per frame and frame clock near falling edges,
 and that the system reset is raised while the bit clock may be stopped.
*/
`timescale 1ns/10ps
module apf_link_rx
(
   input  wire logic                  i_reset,
   input  wire logic                  i_bclk,
   input  wire logic                  i_frame_clk,
   input  wire logic                  i_serial_audio_in,
   output logic                       o_toggle,
   output apf_pkg::apf_frame_s        o_frame,
   output logic [6:0]                 o_ratio
);

   logic [1:0]        rst_sync;
   logic              lr_q;
   logic [6:0]        cnt;
   logic [23:0]       shift;
   logic [4:0]        nbit;
   logic [23:0]       left_word;

   // ------------------------------------------------------------
   // Reset: asserts at once, lets go after two bit clock rises
   // ------------------------------------------------------------
   wire link_rst = rst_sync[1];

   // Keeps the toggle known even while the bit clock is stopped
   always_ff @(posedge i_bclk or posedge i_reset)
   begin
      if (i_reset)
         rst_sync <= 2'b11;
      else
         rst_sync <= {rst_sync[0], 1'b0};
   end

   // ------------------------------------------------------------
   // Shift in MSB first, one bit after each frame clock change
   // ------------------------------------------------------------
   wire lr_edge   = i_frame_clk != lr_q;
   wire frame_end = lr_edge && !i_frame_clk;
   wire [23:0] next_shift = (nbit < 5'd24) ? {shift[22:0], i_serial_audio_in} : shift;

   always_ff @(posedge i_bclk or posedge link_rst)
   begin
      if (link_rst)
      begin
         lr_q  <= 1'b0;
         shift <= 24'h00_0000;
         nbit  <= 5'd0;
         cnt   <= 7'd0;
      end
      else
      begin
         lr_q  <= i_frame_clk;
         shift <= lr_edge ? 24'h00_0000 : next_shift;
         nbit  <= lr_edge ? 5'd0 : ((nbit < 5'd24) ? nbit + 5'd1 : nbit);
         cnt   <= frame_end ? 7'd1 : ((cnt < 7'h7f) ? cnt + 7'd1 : cnt);
      end
   end

   // Frame done flag for the system side, flips once per frame
   always_ff @(posedge i_bclk or posedge link_rst)
   begin
      if (link_rst)
         o_toggle <= 1'b0;
      else if (frame_end)
         o_toggle <= ~o_toggle;
   end

   // Low frame clock carries left, high carries right; the bit at the
   // change still belongs to the word before it (48 clocks per frame)
   always_ff @(posedge i_bclk)
   begin
      if (lr_edge && i_frame_clk)
         left_word <= next_shift;
      if (frame_end)
      begin
         o_frame <= '{left: left_word, right: next_shift};
         o_ratio <= cnt;
      end
   end

endmodule // apf_link_rx

// *** hdl/apf_top.sv ***
/*
 Audio port slave, reset sequencing, fault pin and sticky status register.
 Assumes the controller holds reset and power-down per the timing notes,
 and that faults arrive as levels from protection circuits.
*/
// Behaviour
// - Stay inactive until enabled over control port
// - Drive fault output low on any shutdown
// - Sticky fault bit one at status address two
// - Fault pin zero on error, one otherwise
// - Ratios other than 32, 48, 64 flag clock error
// - I2S: low frame clock left, data one bit later
`timescale 1ns/10ps
module apf_top
#(
   parameter int RESET_HOLD_CYC = apf_pkg::RESET_HOLD_CYC
)
(
   input  wire logic                  i_clk,
   input  wire logic                  i_reset,
   input  wire logic                  i_power_down_n,
   input  wire logic                  i_bclk,
   input  wire logic                  i_frame_clk,
   input  wire logic                  i_serial_audio_in,
   input  wire apf_pkg::apf_fault_s   i_fault,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   input  wire logic [7:0]            i_reg_addr,
   input  wire logic [7:0]            i_reg_wdata,
   input  wire logic                  i_enable_cmd,
   output logic [7:0]                 o_reg_rdata,
   output logic                       o_fault_n,
   output logic                       o_active,
   output logic                       o_clock_error,
   output logic                       o_frame_valid,
   output apf_pkg::apf_frame_s        o_frame
);

   // ------------------------------------------------------------
   // Link side receiver
   // ------------------------------------------------------------
   logic                 link_toggle;
   logic [6:0]           link_ratio;
   apf_pkg::apf_frame_s  link_frame;

   apf_link_rx u_rx
   (
      .i_reset           (i_reset),
      .i_bclk            (i_bclk),
      .i_frame_clk       (i_frame_clk),
      .i_serial_audio_in (i_serial_audio_in),
      .o_toggle          (link_toggle),
      .o_frame           (link_frame),
      .o_ratio           (link_ratio)
   );

   // ------------------------------------------------------------
   // Toggle crossing; frame and ratio are stable for a whole frame
   // ------------------------------------------------------------
   logic [2:0] tog_sync;
   logic [1:0] pdn_sync;
   logic [3:0] fault_meta;
   logic [3:0] fault_sync;

   always_ff @(posedge i_clk)
   begin
      tog_sync   <= {tog_sync[1:0], link_toggle};
      pdn_sync   <= {pdn_sync[0], i_power_down_n};
      fault_meta <= i_fault;
      fault_sync <= fault_meta;
   end

   wire frame_evt  = tog_sync[2] ^ tog_sync[1];
   wire pdn_high   = pdn_sync[1];
   wire any_fault  = |fault_sync;

   // only exact 32, 48 or 64 bit clocks per frame are accepted
   wire ratio_ok = (link_ratio == apf_pkg::RATIO_32) ||
                   (link_ratio == apf_pkg::RATIO_48) ||
                   (link_ratio == apf_pkg::RATIO_64);

   // ------------------------------------------------------------
   // Startup sequence: hold off after reset and power-down release
   // ------------------------------------------------------------
   apf_pkg::apf_state_e state;
   apf_pkg::apf_state_e next_state;
   logic [31:0]         hold_cnt;

   wire hold_done = hold_cnt >= 32'(RESET_HOLD_CYC);

   always_comb
   begin
      next_state = state;
      unique case (state)
         apf_pkg::APF_OFF:    if (pdn_high) next_state = apf_pkg::APF_HOLD;
         apf_pkg::APF_HOLD:   if (!pdn_high) next_state = apf_pkg::APF_OFF;
                              else if (hold_done) next_state = apf_pkg::APF_IDLE;
         apf_pkg::APF_IDLE:   if (!pdn_high) next_state = apf_pkg::APF_OFF;
                              else if (i_enable_cmd) next_state = apf_pkg::APF_ACTIVE;
         apf_pkg::APF_ACTIVE: if (!pdn_high) next_state = apf_pkg::APF_OFF;
      endcase
   end

   // State and settle counter
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state    <= apf_pkg::APF_OFF;
         hold_cnt <= 32'h0000_0000;
      end
      else
      begin
         state    <= next_state;
         hold_cnt <= (state == apf_pkg::APF_HOLD) ? hold_cnt + 32'h0000_0001
                                                  : 32'h0000_0000;
      end
   end

   assign o_active = (state == apf_pkg::APF_ACTIVE);

   // ------------------------------------------------------------
   // Fault pin and status register
   // ------------------------------------------------------------
   logic [7:0] error_status;
   wire        status_hit = i_reg_addr == apf_pkg::ERROR_STATUS_ADDR;
   wire        clr_wr     = i_reg_wr && status_hit;
   wire        clk_err_ev = frame_evt && !ratio_ok;
   wire [7:0]  set_mask   = (8'(any_fault) << apf_pkg::STICKY_FAULT_BIT) |
                            (8'(clk_err_ev) << apf_pkg::CLOCK_ERR_BIT);
   wire [7:0]  clr_mask   = clr_wr ? i_reg_wdata : 8'h00;

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         error_status <= apf_pkg::ERROR_STATUS_RESET;
      else
         error_status <= (error_status & ~clr_mask) | set_mask;
   end

   // Fault pin low while any shutdown source is present
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_fault_n <= 1'b1;
      else
         o_fault_n <= !any_fault;
   end

   // Read port and clock error level
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_reg_rdata   <= 8'h00;
         o_clock_error <= 1'b0;
      end
      else
      begin
         o_reg_rdata   <= (i_reg_rd && status_hit) ? error_status : 8'h00;
         if (frame_evt)
            o_clock_error <= !ratio_ok;
      end
   end

   // Frame valid only while enabled and clock is good; frame data follows every frame
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_frame_valid <= 1'b0;
         o_frame       <= '0;
      end
      else
      begin
         o_frame_valid <= frame_evt && ratio_ok && o_active;
         if (frame_evt)
            o_frame <= link_frame;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_FAULT_PIN: assert property (@(posedge i_clk) disable iff (i_reset)
      any_fault |=> !o_fault_n)
      else $error("fault pin not low on fault");
   AST_FAULT_HIGH: assert property (@(posedge i_clk) disable iff (i_reset)
      !any_fault |=> o_fault_n)
      else $error("fault pin low without fault");
   AST_STICKY_SET: assert property (@(posedge i_clk) disable iff (i_reset)
      any_fault |=> error_status[apf_pkg::STICKY_FAULT_BIT])
      else $error("sticky bit not set");
   AST_STICKY_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
      error_status[apf_pkg::STICKY_FAULT_BIT] && !clr_wr |=>
      error_status[apf_pkg::STICKY_FAULT_BIT])
      else $error("sticky bit lost");
   AST_INACTIVE: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(o_active) |-> $past(i_enable_cmd))
      else $error("active without enable");
   AST_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(state == apf_pkg::APF_IDLE) |-> $past(hold_done))
      else $error("hold time skipped");
   AST_RATIO: assert property (@(posedge i_clk) disable iff (i_reset)
      frame_evt && !ratio_ok |=> o_clock_error)
      else $error("bad ratio not flagged");
   AST_NOFRAME: assert property (@(posedge i_clk) disable iff (i_reset)
      o_frame_valid |-> $past(o_active) && !o_clock_error)
      else $error("frame passed while off");
   AST_RATIO_GOOD: assert property (@(posedge i_clk) disable iff (i_reset)
      frame_evt && ratio_ok |=> !o_clock_error)
      else $error("good ratio flagged as error");
   AST_STICKY_CLR: assert property (@(posedge i_clk) disable iff (i_reset)
      clr_wr && i_reg_wdata[apf_pkg::STICKY_FAULT_BIT] && !any_fault |=>
      !error_status[apf_pkg::STICKY_FAULT_BIT])
      else $error("sticky bit not cleared");

endmodule // apf_top

// *** sim/apf_i2s_src.sv ***
/*
 I2S source model that drives the link side of the audio port.
 Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/10ps
module apf_i2s_src
(
   output logic o_bclk,
   output logic o_frame_clk,
   output logic o_data
);
   logic spill;
   bit   pend;

   // Bit clock stands high while no frame is running
   initial
   begin
      o_bclk = 1'b1;
      o_frame_clk = 1'b1;
      o_data = 1'b0;
      spill = 1'b0;
      pend = 1'b0;
   end

   // One slot: lines change on the falling edge, sampled mid-slot
   task automatic slot(input logic fc, input logic d);
      o_bclk = 1'b0;
      o_frame_clk = fc;
      o_data = d;
      #3 o_bclk = 1'b1;
      #3;
   endtask

   // One stereo frame of n bit clocks, left while frame clock low
   task automatic frame(input int n, input logic [23:0] l, input logic [23:0] r);
      logic [23:0] w;
      int          j;
      for (int k = pend; k < n; k++)
      begin
         j = k % (n / 2);
         w = (k < n / 2) ? l : r;
         if (j == 0) slot(k >= n / 2, spill);
         else if (j <= 24) slot(k >= n / 2, w[24 - j]);
         else slot(k >= n / 2, ~o_data);
         if (j == n / 2 - 1) spill = (n == 48) ? w[0] : ~o_data;
      end
      pend = 1'b0;
   endtask

   // Closing fall of the frame clock, then the data line lets go
   task automatic tail();
      slot(1'b0, spill);
      o_data = ~o_data;
      pend = 1'b1;
   endtask
endmodule // apf_i2s_src

// *** sim/apf_top_tb_top.sv ***
/*
 Self-checking bench for apf_top.
 Assumes apf_i2s_src on the link and a shortened hold count.
*/
`timescale 1ns/10ps
module apf_top_tb_top;
   localparam int HOLD = 20;
   logic                i_clk, i_reset, i_power_down_n, i_enable_cmd;
   logic                i_reg_wr, i_reg_rd, o_fault_n, o_active;
   logic                bclk, fclk, sdata, o_clock_error, o_frame_valid;
   logic [7:0]          i_reg_addr, i_reg_wdata, o_reg_rdata;
   apf_pkg::apf_fault_s i_fault;
   apf_pkg::apf_frame_s o_frame, last;
   int                  errors, tests_run, nval;

   apf_top #(.RESET_HOLD_CYC(HOLD)) apf_top_inst
   (
      .i_clk(i_clk), .i_reset(i_reset), .i_power_down_n(i_power_down_n),
      .i_bclk(bclk), .i_frame_clk(fclk), .i_serial_audio_in(sdata),
      .i_fault(i_fault), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_enable_cmd(i_enable_cmd), .o_reg_rdata(o_reg_rdata),
      .o_fault_n(o_fault_n), .o_active(o_active),
      .o_clock_error(o_clock_error), .o_frame_valid(o_frame_valid),
      .o_frame(o_frame)
   );
   apf_i2s_src apf_i2s_src_inst (.o_bclk(bclk), .o_frame_clk(fclk), .o_data(sdata));

   // System clock
   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   // Count accepted frames and keep the latest
   always @(posedge i_clk)
      if (o_frame_valid === 1'b1)
      begin
         nval <= nval + 1;
         last <= o_frame;
      end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1 chk(o_reg_rdata, exp);
   endtask

   task automatic enable();
      @(posedge i_clk);
      i_enable_cmd <= 1'b1;
      @(posedge i_clk);
      i_enable_cmd <= 1'b0;
   endtask

   // Leave power-down; an early enable must be ignored
   task automatic power_up();
      @(posedge i_clk);
      i_power_down_n <= 1'b1;
      enable();
      cyc(4);
      chk(o_active, 1'b0);
      cyc(HOLD + 6);
      enable();
      cyc(2);
      chk(o_active, 1'b1);
   endtask

   // One frame of n bit clocks; e says whether it must be refused
   task automatic fr(input int n, input logic e);
      int v;
      v = nval;
      apf_i2s_src_inst.frame(n, 24'hA5_C3E1, 24'h3C_5A96);
      apf_i2s_src_inst.tail();
      cyc(20);
      chk(o_clock_error, e);
      chk(nval - v, !e);
      if (n != 32) chk(last, 48'hA5C3_E13C_5A96);
   endtask

   task automatic wrap_up();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {errors, tests_run, nval} = '0;
      {i_reset, i_power_down_n, i_enable_cmd, i_reg_wr, i_reg_rd} <= 5'b1_0000;
      {i_reg_addr, i_reg_wdata} = '0;
      i_fault = '0;
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      cyc(2);
      chk(o_active, 1'b0);
      power_up();
      i_power_down_n <= 1'b0;
      cyc(6);
      chk(o_active, 1'b0);
      power_up();
      apf_i2s_src_inst.frame(64, 24'h00_0000, 24'h00_0000);
      apf_i2s_src_inst.tail();
      cyc(20);
      wr(8'h02, 8'h03);
      fr(32, 1'b0);
      fr(48, 1'b0);
      fr(64, 1'b0);
      fr(40, 1'b1);
      rd(8'h02, 8'h01);
      wr(8'h02, 8'h01);
      fr(64, 1'b0);
      rd(8'h05, 8'h00);
      wr(8'h05, 8'hFF);
      rd(8'h02, 8'h00);
      for (int b = 0; b < 4; b++)
      begin
         @(posedge i_clk);
         i_fault <= 4'b1000 >> b;
         cyc(6);
         chk(o_fault_n, 1'b0);
         wr(8'h02, 8'h02);
         rd(8'h02, 8'h02);
         @(posedge i_clk);
         i_fault <= '0;
         cyc(6);
         chk(o_fault_n, 1'b1);
         rd(8'h02, 8'h02);
         wr(8'h02, 8'h02);
         rd(8'h02, 8'h00);
      end
      wrap_up();
   end

   // Watchdog: the tests need under a thousand cycles
   initial
   begin
      #80000;
      errors++;
      wrap_up();
   end
endmodule // apf_top_tb_top
